// ### common/cond_pkg.sv
// Functional notes
// - Current converters deliver signed 24-bit samples at 8 kSPS into the path.
// - Full-scale current input swings between 0xA58AC0 and 0x5A7540.
// - Current sample times one plus signed 24-bit gain over two to the 23.
// - Current gain change affects all downstream results and stored samples.
// - Gain reads give 32 bits: top four zero, sign-extended to 28.
// - Filter-disable zero enables all high-pass filters; any nonzero disables them.
// - Filter-disable reads as 32 bits with upper 8 bits zero.
// - Post-filter current samples stored in four 24-bit registers at 8 kSPS.
// - Data-ready flag at status bit 17; same mask bit enables its interrupt.
// - Waveform sample reads are sign-extended to 32 bits.
// - Per-current integrator, off after reset, enabled by configuration bit 0.
// - Coefficient register accessed as 32 bits, top four zero, sign-extended to 28.
// - Integrator falls at -20 dB/dec with about -90 degree phase shift.
// - Voltage converters deliver signed 24-bit samples at 8 kSPS.
// - Voltage sample times one plus signed 24-bit gain over two to the 23.
// - Voltage gain change affects that phase's results and stored samples.
// - Post-filter voltage samples stored in three 24-bit registers, same ready flag.
package cond_pkg;
	// Timing
	localparam int CLK_HZ = 25_000_000;
	localparam int SAMPLE_HZ = 8_000;
	localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
	localparam int DIV_W = 12;

	// Widths and channel counts
	localparam int SAMPLE_W = 24;
	localparam int DSP_W = 28;
	localparam int BUS_W = 32;
	localparam int GAIN_FRAC = 23;
	localparam int NUM_CURRENT = 4;
	localparam int NUM_VOLTAGE = 3;
	localparam int ADDR_W = 5;

	// Filter shaping
	localparam int HPF_FRAC = 8;
	localparam int HPF_SHIFT = 10;
	localparam int INTEG_IN_SHIFT = 4;

	// Codes
	localparam logic [23:0] FULL_SCALE_POS = 24'h5A_7540;
	localparam logic [23:0] FULL_SCALE_NEG = 24'hA5_8AC0;
	localparam logic [23:0] INTEG_COEFF_REQUIRED = 24'hFF_8000;
	localparam logic signed [24:0] UNITY_GAIN = 25'sh080_0000;
	localparam logic signed [31:0] SAMPLE_MAX_32 = 32'sh007F_FFFF;
	localparam logic signed [31:0] SAMPLE_MIN_32 = 32'shFF80_0000;
	localparam logic signed [31:0] DSP_MAX_32 = 32'sh07FF_FFFF;
	localparam logic signed [31:0] DSP_MIN_32 = 32'shF800_0000;

	// Reset values
	localparam logic [23:0] GAIN_RESET = 24'h00_0000;
	localparam logic [23:0] HPF_DISABLE_RESET = 24'h00_0000;
	localparam logic [23:0] INTEG_COEFF_RESET = 24'h00_0000;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	localparam logic [31:0] FIRST_MASK_REGISTER_RESET = 32'h0000_0000;

	// Bit positions
	localparam int INTEGRATOR_ENABLE_BIT = 0;
	localparam int SAMPLE_READY_BIT = 17;

	// Register indices
	localparam logic [4:0] REG_PHASE_A_CURRENT_GAIN = 5'h00;
	localparam logic [4:0] REG_PHASE_B_CURRENT_GAIN = 5'h01;
	localparam logic [4:0] REG_PHASE_C_CURRENT_GAIN = 5'h02;
	localparam logic [4:0] REG_NEUTRAL_CURRENT_GAIN = 5'h03;
	localparam logic [4:0] REG_PHASE_A_VOLTAGE_GAIN = 5'h04;
	localparam logic [4:0] REG_PHASE_B_VOLTAGE_GAIN = 5'h05;
	localparam logic [4:0] REG_PHASE_C_VOLTAGE_GAIN = 5'h06;
	localparam logic [4:0] REG_HIGHPASS_DISABLE = 5'h07;
	localparam logic [4:0] REG_INTEGRATOR_COEFFICIENT = 5'h08;
	localparam logic [4:0] REG_CONFIG = 5'h09;
	localparam logic [4:0] REG_FIRST_STATUS = 5'h0A;
	localparam logic [4:0] REG_FIRST_MASK = 5'h0B;
	localparam logic [4:0] REG_PHASE_A_CURRENT_SAMPLE = 5'h10;
	localparam logic [4:0] REG_PHASE_B_CURRENT_SAMPLE = 5'h11;
	localparam logic [4:0] REG_PHASE_C_CURRENT_SAMPLE = 5'h12;
	localparam logic [4:0] REG_NEUTRAL_CURRENT_SAMPLE = 5'h13;
	localparam logic [4:0] REG_PHASE_A_VOLTAGE_SAMPLE = 5'h14;
	localparam logic [4:0] REG_PHASE_B_VOLTAGE_SAMPLE = 5'h15;
	localparam logic [4:0] REG_PHASE_C_VOLTAGE_SAMPLE = 5'h16;

	// Serial-port register request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [31:0] wdata;
	} reg_req_s;

	// One frame of converter outputs; index 0..3 = A, B, C, neutral
	typedef struct packed {
		logic [3:0][23:0] current;
		logic [2:0][23:0] voltage;
	} adc_frame_s;

	// Clip a wide signed value to the 24-bit sample range
	function automatic logic [23:0] sat_to_sample(input logic signed [31:0] v);
		if (v > SAMPLE_MAX_32) begin
			return SAMPLE_MAX_32[23:0];
		end else if (v < SAMPLE_MIN_32) begin
			return SAMPLE_MIN_32[23:0];
		end else begin
			return v[23:0];
		end
	endfunction

	// Clip a wide signed value to the 28-bit DSP range
	function automatic logic [27:0] sat_to_dsp(input logic signed [31:0] v);
		if (v > DSP_MAX_32) begin
			return DSP_MAX_32[27:0];
		end else if (v < DSP_MIN_32) begin
			return DSP_MIN_32[27:0];
		end else begin
			return v[27:0];
		end
	endfunction

	// 24-bit value, sign-extended to 28, top nibble zero
	function automatic logic [31:0] dsp_word(input logic [23:0] v);
		return {4'h0, {4{v[23]}}, v};
	endfunction

	// 24-bit value sign-extended to a full word
	function automatic logic [31:0] sample_word(input logic [23:0] v);
		return {{8{v[23]}}, v};
	endfunction
endpackage

// ### hw/gain_stage.sv
`timescale 1ns/100ps
module gain_stage
	import cond_pkg::*;
(
	input wire logic signed [SAMPLE_W-1:0] din,
	input wire logic signed [SAMPLE_W-1:0] gain,
	output logic signed [SAMPLE_W-1:0] dout
);
	logic signed [SAMPLE_W:0] factor;
	logic signed [2*SAMPLE_W:0] product;
	logic signed [DSP_W-1:0] scaled;

	// Factor is unity plus gain; gain of full negative code mutes the channel
	assign factor = $signed({gain[SAMPLE_W-1], gain}) + UNITY_GAIN;
	assign product = din * factor;
	// Drop the 23 fraction bits, carry at 28 bits, then clip
	assign scaled = DSP_W'($signed(product[2*SAMPLE_W:GAIN_FRAC]));
	assign dout = sat_to_sample(32'(scaled));
endmodule

// ### hw/chan_filter.sv
`timescale 1ns/100ps
module chan_filter
	import cond_pkg::*;
#(
	parameter bit HAS_INTEG = 1'b1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic hpf_on,
	input wire logic integ_on,
	input wire logic signed [SAMPLE_W-1:0] coeff,
	input wire logic signed [SAMPLE_W-1:0] din,
	output logic signed [SAMPLE_W-1:0] dout
);
	logic signed [31:0] dc_r;
	logic signed [32:0] err;
	logic signed [31:0] hp_wide;
	logic signed [SAMPLE_W-1:0] stage1;
	logic signed [DSP_W-1:0] acc_r;
	logic signed [DSP_W-1:0] acc_nxt;
	logic signed [DSP_W+SAMPLE_W-1:0] leak_prod;
	logic signed [31:0] acc_sum;
	logic integ_active;

	// First-order dc tracker; output is input minus tracked offset
	assign err = 33'($signed({din, 8'h00})) - 33'(dc_r);
	assign hp_wide = 32'(din) - (dc_r >>> HPF_FRAC);
	assign stage1 = hpf_on ? sat_to_sample(hp_wide) : din;

	// Leaky accumulator: coefficient sets the leak, giving a 1/f slope
	assign integ_active = HAS_INTEG && integ_on;
	assign leak_prod = acc_r * coeff;
	assign acc_sum = 32'(acc_r) + 32'(stage1 >>> INTEG_IN_SHIFT)
		+ 32'($signed(leak_prod[DSP_W+SAMPLE_W-1:GAIN_FRAC]));
	assign acc_nxt = sat_to_dsp(acc_sum);

	// Offset tracker; cleared while bypassed so re-enable starts clean
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dc_r <= 32'sh0000_0000;
		end else if (!hpf_on) begin
			dc_r <= 32'sh0000_0000;
		end else if (en) begin
			dc_r <= dc_r + 32'(err >>> HPF_SHIFT);
		end
	end

	// Integrator state; held at zero while switched off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_r <= 28'sh000_0000;
		end else if (!integ_active) begin
			acc_r <= 28'sh000_0000;
		end else if (en) begin
			acc_r <= acc_nxt;
		end
	end

	// Registered channel output
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout <= 24'sh00_0000;
		end else if (en) begin
			dout <= integ_active ? sat_to_sample(32'(acc_nxt)) : stage1;
		end
	end
endmodule

// ### hw/cond_top.sv
`timescale 1ns/100ps
module cond_top
	import cond_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire adc_frame_s adc_in,
	input wire reg_req_s reg_req,
	output logic [BUS_W-1:0] reg_rdata,
	output logic reg_rvalid,
	output adc_frame_s cond_out,
	output logic cond_valid,
	output logic sample_ready_irq
);
	logic [DIV_W-1:0] div_cnt_r;
	logic sample_tick;
	logic stage_en_r;
	logic capture_en_r;
	adc_frame_s frame_r;
	logic [NUM_CURRENT-1:0][SAMPLE_W-1:0] current_gain_r;
	logic [NUM_VOLTAGE-1:0][SAMPLE_W-1:0] voltage_gain_r;
	logic [SAMPLE_W-1:0] highpass_disable_r;
	logic [SAMPLE_W-1:0] integrator_coefficient_r;
	logic [15:0] config_r;
	logic [BUS_W-1:0] first_mask_register_r;
	logic sample_ready_flag_r;
	logic [NUM_CURRENT-1:0][SAMPLE_W-1:0] current_sample_r;
	logic [NUM_VOLTAGE-1:0][SAMPLE_W-1:0] voltage_sample_r;
	logic [NUM_CURRENT-1:0][SAMPLE_W-1:0] current_scaled;
	logic [NUM_VOLTAGE-1:0][SAMPLE_W-1:0] voltage_scaled;
	logic [NUM_CURRENT-1:0][SAMPLE_W-1:0] current_filt;
	logic [NUM_VOLTAGE-1:0][SAMPLE_W-1:0] voltage_filt;
	logic hpf_on;
	logic integrator_enable;
	logic wr_status;
	logic [BUS_W-1:0] read_value;

	// Sample-rate divider: one pulse every SAMPLE_DIV clocks
	assign sample_tick = (div_cnt_r == DIV_W'(SAMPLE_DIV - 1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_r <= '0;
		end else if (sample_tick) begin
			div_cnt_r <= '0;
		end else begin
			div_cnt_r <= div_cnt_r + DIV_W'(1);
		end
	end

	// Converter words are taken once per sample period, full 24-bit range
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_r <= '0;
		end else if (sample_tick) begin
			frame_r <= adc_in;
		end
	end

	// Two-stage pipeline strobes: filter update, then capture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage_en_r <= 1'b0;
			capture_en_r <= 1'b0;
		end else begin
			stage_en_r <= sample_tick;
			capture_en_r <= stage_en_r;
		end
	end

	// One global filter switch; any nonzero bit disables every channel
	assign hpf_on = (highpass_disable_r == HPF_DISABLE_RESET);
	assign integrator_enable = config_r[INTEGRATOR_ENABLE_BIT];

	// Current channels: gain, high-pass, optional integrator
	for (genvar i = 0; i < NUM_CURRENT; i++) begin : g_current
		gain_stage u_gain (
			.din(frame_r.current[i]),
			.gain(current_gain_r[i]),
			.dout(current_scaled[i])
		);
		chan_filter #(
			.HAS_INTEG(1'b1)
		) u_filt (
			.clk(clk),
			.rst_b(rst_b),
			.en(stage_en_r),
			.hpf_on(hpf_on),
			.integ_on(integrator_enable),
			.coeff(integrator_coefficient_r),
			.din(current_scaled[i]),
			.dout(current_filt[i])
		);
	end

	// Voltage channels: gain and high-pass only
	for (genvar j = 0; j < NUM_VOLTAGE; j++) begin : g_voltage
		gain_stage u_gain (
			.din(frame_r.voltage[j]),
			.gain(voltage_gain_r[j]),
			.dout(voltage_scaled[j])
		);
		chan_filter #(
			.HAS_INTEG(1'b0)
		) u_filt (
			.clk(clk),
			.rst_b(rst_b),
			.en(stage_en_r),
			.hpf_on(hpf_on),
			.integ_on(1'b0),
			.coeff(integrator_coefficient_r),
			.din(voltage_scaled[j]),
			.dout(voltage_filt[j])
		);
	end

	// Waveform registers; the same words feed the downstream stream
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			current_sample_r <= '0;
			voltage_sample_r <= '0;
		end else if (capture_en_r) begin
			current_sample_r <= current_filt;
			voltage_sample_r <= voltage_filt;
		end
	end

	// Downstream stream, scaled by the gains like the stored samples
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cond_out <= '0;
			cond_valid <= 1'b0;
		end else begin
			cond_valid <= capture_en_r;
			if (capture_en_r) begin
				cond_out.current <= current_filt;
				cond_out.voltage <= voltage_filt;
			end
		end
	end

	// Current gain registers, low 24 bits of the written word kept
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			current_gain_r <= {NUM_CURRENT{GAIN_RESET}};
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				REG_PHASE_A_CURRENT_GAIN: current_gain_r[0] <= reg_req.wdata[SAMPLE_W-1:0];
				REG_PHASE_B_CURRENT_GAIN: current_gain_r[1] <= reg_req.wdata[SAMPLE_W-1:0];
				REG_PHASE_C_CURRENT_GAIN: current_gain_r[2] <= reg_req.wdata[SAMPLE_W-1:0];
				REG_NEUTRAL_CURRENT_GAIN: current_gain_r[3] <= reg_req.wdata[SAMPLE_W-1:0];
				default: current_gain_r <= current_gain_r;
			endcase
		end
	end

	// Voltage gain registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			voltage_gain_r <= {NUM_VOLTAGE{GAIN_RESET}};
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				REG_PHASE_A_VOLTAGE_GAIN: voltage_gain_r[0] <= reg_req.wdata[SAMPLE_W-1:0];
				REG_PHASE_B_VOLTAGE_GAIN: voltage_gain_r[1] <= reg_req.wdata[SAMPLE_W-1:0];
				REG_PHASE_C_VOLTAGE_GAIN: voltage_gain_r[2] <= reg_req.wdata[SAMPLE_W-1:0];
				default: voltage_gain_r <= voltage_gain_r;
			endcase
		end
	end

	// Filter switch, coefficient, configuration and mask
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			highpass_disable_r <= HPF_DISABLE_RESET;
			integrator_coefficient_r <= INTEG_COEFF_RESET;
			config_r <= CONFIG_RESET;
			first_mask_register_r <= FIRST_MASK_REGISTER_RESET;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				REG_HIGHPASS_DISABLE: highpass_disable_r <= reg_req.wdata[SAMPLE_W-1:0];
				REG_INTEGRATOR_COEFFICIENT: integrator_coefficient_r <= reg_req.wdata[SAMPLE_W-1:0];
				REG_CONFIG: config_r <= reg_req.wdata[15:0];
				REG_FIRST_MASK: first_mask_register_r <= reg_req.wdata;
				default: config_r <= config_r;
			endcase
		end
	end

	// Ready flag: write one to clear; a new capture wins over the clear
	assign wr_status = reg_req.wr && (reg_req.addr == REG_FIRST_STATUS);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_ready_flag_r <= 1'b0;
		end else if (capture_en_r) begin
			sample_ready_flag_r <= 1'b1;
		end else if (wr_status && reg_req.wdata[SAMPLE_READY_BIT]) begin
			sample_ready_flag_r <= 1'b0;
		end
	end

	// Interrupt request level, masked by the same bit position
	assign sample_ready_irq = sample_ready_flag_r && first_mask_register_r[SAMPLE_READY_BIT];

	// Read formatting per register kind
	always_comb begin
		read_value = '0;
		case (reg_req.addr)
			REG_PHASE_A_CURRENT_GAIN: read_value = dsp_word(current_gain_r[0]);
			REG_PHASE_B_CURRENT_GAIN: read_value = dsp_word(current_gain_r[1]);
			REG_PHASE_C_CURRENT_GAIN: read_value = dsp_word(current_gain_r[2]);
			REG_NEUTRAL_CURRENT_GAIN: read_value = dsp_word(current_gain_r[3]);
			REG_PHASE_A_VOLTAGE_GAIN: read_value = dsp_word(voltage_gain_r[0]);
			REG_PHASE_B_VOLTAGE_GAIN: read_value = dsp_word(voltage_gain_r[1]);
			REG_PHASE_C_VOLTAGE_GAIN: read_value = dsp_word(voltage_gain_r[2]);
			REG_HIGHPASS_DISABLE: read_value = {8'h00, highpass_disable_r};
			REG_INTEGRATOR_COEFFICIENT: read_value = dsp_word(integrator_coefficient_r);
			REG_CONFIG: read_value = {16'h0000, config_r};
			REG_FIRST_STATUS: read_value = BUS_W'(sample_ready_flag_r) << SAMPLE_READY_BIT;
			REG_FIRST_MASK: read_value = first_mask_register_r;
			REG_PHASE_A_CURRENT_SAMPLE: read_value = sample_word(current_sample_r[0]);
			REG_PHASE_B_CURRENT_SAMPLE: read_value = sample_word(current_sample_r[1]);
			REG_PHASE_C_CURRENT_SAMPLE: read_value = sample_word(current_sample_r[2]);
			REG_NEUTRAL_CURRENT_SAMPLE: read_value = sample_word(current_sample_r[3]);
			REG_PHASE_A_VOLTAGE_SAMPLE: read_value = sample_word(voltage_sample_r[0]);
			REG_PHASE_B_VOLTAGE_SAMPLE: read_value = sample_word(voltage_sample_r[1]);
			REG_PHASE_C_VOLTAGE_SAMPLE: read_value = sample_word(voltage_sample_r[2]);
			default: read_value = '0;
		endcase
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd) begin
				reg_rdata <= read_value;
			end
		end
	end
endmodule

// ### testbench/cond_monitor.sv
`timescale 1ns/100ps
module cond_monitor
	import cond_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire reg_req_s reg_req,
	input wire logic [BUS_W-1:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire adc_frame_s cond_out,
	input wire logic cond_valid,
	input wire logic sample_ready_irq
);
	logic [11:0] gap_r;
	logic seen_r;
	default clocking mc @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Gap since last frame; the first frame has no predecessor to measure
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_r <= 12'h000;
			seen_r <= 1'b0;
		end else if (cond_valid) begin
			gap_r <= 12'h000;
			seen_r <= 1'b1;
		end else begin
			gap_r <= gap_r + 12'h001;
		end
	end
	sequence s_rd;
		reg_req.rd;
	endsequence
	sequence s_flag_clr;
		reg_req.wr && reg_req.addr == REG_FIRST_STATUS && reg_req.wdata[SAMPLE_READY_BIT];
	endsequence
	a_read_answer: assert property (s_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
		else $error("read answer without request");
	a_gain_format: assert property (reg_rvalid && $past(reg_req.addr) <= REG_INTEGRATOR_COEFFICIENT
		&& $past(reg_req.addr) != REG_HIGHPASS_DISABLE
		|-> reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}})
		else $error("gain word not padded and extended");
	a_filter_format: assert property (reg_rvalid && $past(reg_req.addr) == REG_HIGHPASS_DISABLE
		|-> reg_rdata[31:24] == 8'h00)
		else $error("filter-disable top byte not zero");
	a_sample_sext: assert property (reg_rvalid && $past(reg_req.addr) >= REG_PHASE_A_CURRENT_SAMPLE
		&& $past(reg_req.addr) <= REG_PHASE_C_VOLTAGE_SAMPLE |-> reg_rdata[31:24] == {8{reg_rdata[23]}})
		else $error("sample word not sign extended");
	a_unmapped_zero: assert property (reg_rvalid && ($past(reg_req.addr) > REG_PHASE_C_VOLTAGE_SAMPLE
		|| ($past(reg_req.addr) > REG_FIRST_MASK && $past(reg_req.addr) < REG_PHASE_A_CURRENT_SAMPLE))
		|-> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_valid_pulse: assert property (cond_valid |=> !cond_valid)
		else $error("frame strobe longer than one cycle");
	a_frame_period: assert property (cond_valid && seen_r |-> gap_r == 12'(SAMPLE_DIV - 1))
		else $error("frame period wrong");
	a_out_hold: assert property (!cond_valid |-> $stable(cond_out))
		else $error("conditioned output moved between frames");
	a_irq_cause: assert property ($rose(sample_ready_irq)
		|-> cond_valid || $past(reg_req.wr && reg_req.addr == REG_FIRST_MASK))
		else $error("ready interrupt rose without cause");
	a_flag_clear: assert property (s_flag_clr |=> !sample_ready_irq || cond_valid)
		else $error("ready flag not cleared");
endmodule
bind cond_top cond_monitor mon (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .cond_out(cond_out), .cond_valid(cond_valid), .sample_ready_irq(sample_ready_irq));

// ### testbench/host_model.sv
`timescale 1ns/100ps
module host_model
	import cond_pkg::*;
(
	input wire logic clk,
	output reg_req_s reg_req,
	input wire logic [BUS_W-1:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_req = '0;
	end
	// Idle bus carries inverted junk so a stale address is never trusted
	task automatic write_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(posedge clk);
		#1;
		reg_req.wr = 1'b0;
		reg_req.addr = ~a;
		reg_req.wdata = ~d;
	endtask
	// Answer registered at the take edge, so it is looked at just after it
	task automatic read_reg(input logic [4:0] a, output logic [31:0] d, output logic ok);
		@(posedge clk);
		#1;
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(posedge clk);
		#1;
		reg_req.rd = 1'b0;
		reg_req.addr = ~a;
		ok = (reg_rvalid === 1'b1);
		d = reg_rdata;
	endtask
	// Coefficient first, then the enable bit
	task automatic enable_integrator();
		write_reg(REG_INTEGRATOR_COEFFICIENT, {8'h00, INTEG_COEFF_REQUIRED});
		write_reg(REG_CONFIG, 32'h0000_0001);
	endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench
	import cond_pkg::*;
;
	logic clk;
	logic rst_b;
	adc_frame_s adc_in;
	reg_req_s reg_req;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	adc_frame_s cond_out;
	logic cond_valid;
	logic sample_ready_irq;
	int fail_count;
	int n_checks;
	logic [31:0] rd_d;
	logic rd_ok;
	logic [23:0] o1;
	localparam logic [23:0] INS [7] = '{24'h5A_7540, 24'h5A_7540, 24'h5A_7540, 24'hA5_8AC0,
		24'h10_0000, 24'h5A_7540, 24'hA5_8AC0};
	localparam logic [23:0] GAINS [2][7] = '{
		'{24'h40_0000, 24'hC0_0000, 24'h00_0000, 24'h7F_FFFF, 24'h20_0000, 24'h80_0000, 24'h00_0000},
		'{24'hE0_0000, 24'h20_0000, 24'h00_0000, 24'h80_0000, 24'hC0_0000, 24'h7F_FFFF, 24'h40_0000}};

	cond_top dut (.clk(clk), .rst_b(rst_b), .adc_in(adc_in), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .cond_out(cond_out), .cond_valid(cond_valid), .sample_ready_irq(sample_ready_irq));
	host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Scaled and clipped reference, worked out wide to avoid overflow
	function automatic logic [23:0] exp_gain(input logic [23:0] x, input logic [23:0] g);
		logic signed [63:0] p;
		p = $signed({{40{x[23]}}, x}) * ($signed({{40{g[23]}}, g}) + 64'sd8388608);
		p = p >>> 23;
		if (p > 64'sd8388607) return 24'h7F_FFFF;
		if (p < -64'sd8388608) return 24'h80_0000;
		return p[23:0];
	endfunction
	function automatic logic [23:0] out_of(input int i);
		return (i < 4) ? cond_out.current[i] : cond_out.voltage[i-4];
	endfunction

	task automatic complete_run();
		$display("Checks %0d, errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("Error at %0t: word got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic check_samp(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("Error at %0t: sample got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			$display("Error at %0t: flag got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic check_read(input logic [4:0] a, input logic [31:0] exp);
		host.read_reg(a, rd_d, rd_ok);
		check_bit(rd_ok, 1'b1);
		check_reg(rd_d, exp);
	endtask
	// Bounded wait for the next conditioned frame strobe
	task automatic wait_frame();
		int k;
		k = 0;
		@(posedge clk);
		#1;
		while (cond_valid !== 1'b1 && k < 3300) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (cond_valid !== 1'b1) begin
			$display("Error at %0t: frame wait got %h expected %h", $time, cond_valid, 1'b1);
			fail_count++;
			complete_run();
		end
	endtask

	initial begin
		logic [31:0] d;
		logic [23:0] e;
		fail_count = 0;
		n_checks = 0;
		rst_b = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (i < 4) adc_in.current[i] = INS[i];
			else adc_in.voltage[i-4] = INS[i];
		end
		repeat (3) @(posedge clk);
		#1;
		rst_b = 1'b1;
		// Every index, mapped or not, is zero after reset
		for (int a = 0; a < 32; a++) begin
			check_read(a[4:0], 32'h0000_0000);
		end
		// Word formats; sample registers ignore writes
		for (int j = 0; j < 7; j++) begin
			d = {GAINS[0][j][7:0], GAINS[1][j]};
			for (int a = 0; a < 9; a++) host.write_reg(a[4:0], d);
			host.write_reg(REG_PHASE_A_CURRENT_SAMPLE, d);
			for (int a = 0; a < 9; a++) begin
				check_read(a[4:0], (a == 7) ? {8'h00, d[23:0]} : {4'h0, {4{d[23]}}, d[23:0]});
			end
			check_read(REG_PHASE_A_CURRENT_SAMPLE, 32'h0000_0000);
		end
		// Filters off by a nonzero middle bit, then two gain sets
		host.write_reg(REG_HIGHPASS_DISABLE, 32'h0000_0100);
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 7; i++) host.write_reg(i[4:0], {8'h00, GAINS[s][i]});
			wait_frame();
			wait_frame();
			for (int i = 0; i < 7; i++) begin
				e = exp_gain(INS[i], GAINS[s][i]);
				check_samp(out_of(i), e);
				check_read(REG_PHASE_A_CURRENT_SAMPLE + i[4:0], {{8{e[23]}}, e});
			end
			host.read_reg(REG_FIRST_STATUS, rd_d, rd_ok);
			check_bit(rd_d[SAMPLE_READY_BIT], 1'b1);
			host.write_reg(REG_FIRST_STATUS, 32'h0002_0000);
			host.read_reg(REG_FIRST_STATUS, rd_d, rd_ok);
			check_bit(rd_d[SAMPLE_READY_BIT], 1'b0);
		end
		// Ready interrupt: masked in, cleared, masked out
		host.write_reg(REG_FIRST_MASK, 32'h0002_0000);
		check_read(REG_FIRST_MASK, 32'h0002_0000);
		wait_frame();
		check_bit(sample_ready_irq, 1'b1);
		host.write_reg(REG_FIRST_STATUS, 32'h0002_0000);
		check_bit(sample_ready_irq, 1'b0);
		host.write_reg(REG_FIRST_MASK, 32'h0000_0000);
		wait_frame();
		check_bit(sample_ready_irq, 1'b0);
		// Filters on: a steady offset starts to be removed
		host.write_reg(REG_HIGHPASS_DISABLE, 32'h0000_0000);
		repeat (3) wait_frame();
		check_bit($signed(cond_out.current[2]) < $signed(INS[2]), 1'b1);
		// Integrator on: steady input ramps, voltage path untouched
		host.write_reg(REG_HIGHPASS_DISABLE, 32'h0000_0001);
		host.enable_integrator();
		check_read(REG_INTEGRATOR_COEFFICIENT, 32'h0FFF_8000);
		repeat (2) wait_frame();
		o1 = cond_out.current[2];
		wait_frame();
		check_bit($signed(cond_out.current[2]) > $signed(o1), 1'b1);
		check_samp(cond_out.voltage[2], exp_gain(INS[6], GAINS[1][6]));
		host.write_reg(REG_CONFIG, 32'h0000_0000);
		repeat (2) wait_frame();
		check_samp(cond_out.current[2], exp_gain(INS[2], GAINS[1][2]));
		complete_run();
	end
endmodule
